// file: core/dagp_port.sv
// Three-pin tri-state general-purpose port of a debug adapter.
// Assumes a single 200 MHz clock; pins are resolved outside from pin_oe.
`include "dagp_params.svh"
`default_nettype none

// Behaviour
// - Three pins, each host-selectable input or tri-state output.
// - After reset all output drivers are off; pins float.
// - A pin drives only with port enabled and its direction output, save pin two in reset mode.
// - Disabling the port releases every pin at once, save pin two in reset mode.
// - Port enable honoured only while scan and serial ports are disabled.
// - Scan engine accepts formats JScan0-3, MScan, OScan0-7.
// - Scan engine works both four-wire and two-wire chains.
// - Pin two serves as processor reset; general use then blocked.
// - Serial ports six and seven refused while pin two is reset.
module dagp_port (
   input  wire logic                      clock,
   input  wire logic                      rst,
   input  wire dagp_pkg::dagp_cfg_type    cfg,
   input  wire logic                      scan_port_enabled,
   input  wire logic                      spi_port_enabled,
   input  wire logic [2:0]                spi_port_select,
   input  wire logic                      reset_pin_mode,
   input  wire logic                      proc_reset_request,
   input  wire dagp_pkg::dagp_format_type scan_format,
   input  wire logic                      scan_two_wire,
   input  wire logic [`DAGP_PIN_COUNT-1:0] pin_in,
   output logic      [`DAGP_PIN_COUNT-1:0] pin_out,
   output logic      [`DAGP_PIN_COUNT-1:0] pin_oe,
   output logic      [`DAGP_PIN_COUNT-1:0] pin_in_value,
   output logic                           port_active,
   output logic                           port_refused,
   output logic                           spi_select_refused,
   output logic                           scan_format_ok
);

   // ==========================================================
   // Input synchronisers
   logic [`DAGP_PIN_COUNT-1:0] sync1_reg;
   logic [`DAGP_PIN_COUNT-1:0] sync2_reg;
   logic [`DAGP_PIN_COUNT-1:0] in_value_reg;

   always_ff @(posedge clock) begin
      if (rst) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         in_value_reg <= 3'h0;
      end else begin
         in_value_reg <= sync2_reg;
      end
   end
   assign pin_in_value = in_value_reg;

   // ==========================================================
   // Port ownership
   dagp_pkg::dagp_state_type state_reg;
   dagp_pkg::dagp_state_type state_next;
   logic                     conflict;

   assign conflict = scan_port_enabled | spi_port_enabled;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dagp_pkg::DAGP_ST_IDLE: begin
            if (cfg.port_enable && conflict) begin
               state_next = dagp_pkg::DAGP_ST_BLOCKED;
            end else if (cfg.port_enable) begin
               state_next = dagp_pkg::DAGP_ST_ACTIVE;
            end
         end
         dagp_pkg::DAGP_ST_ACTIVE: begin
            if (!cfg.port_enable) begin
               state_next = dagp_pkg::DAGP_ST_IDLE;
            end else if (conflict) begin
               state_next = dagp_pkg::DAGP_ST_BLOCKED;
            end
         end
         dagp_pkg::DAGP_ST_BLOCKED: begin
            if (!cfg.port_enable) begin
               state_next = dagp_pkg::DAGP_ST_IDLE;
            end
         end
         default: state_next = dagp_pkg::DAGP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= dagp_pkg::DAGP_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign port_active  = (state_reg == dagp_pkg::DAGP_ST_ACTIVE);
   assign port_refused = (state_reg == dagp_pkg::DAGP_ST_BLOCKED);

   // ==========================================================
   // Output drivers
   logic [`DAGP_PIN_COUNT-1:0] out_reg;
   logic [`DAGP_PIN_COUNT-1:0] oe_reg;
   logic [`DAGP_PIN_COUNT-1:0] oe_next;
   logic [`DAGP_PIN_COUNT-1:0] out_next;

   genvar g;
   generate
      for (g = 0; g < `DAGP_PIN_COUNT; g++) begin : g_pin
         if (g == `DAGP_RESET_PIN_INDEX) begin : g_rst
            // Reset mode: drive processor reset low, else release
            always_comb begin
               if (reset_pin_mode) begin
                  oe_next[g]  = proc_reset_request;
                  out_next[g] = 1'b0;
               end else begin
                  oe_next[g]  = (state_next == dagp_pkg::DAGP_ST_ACTIVE) && cfg.dir_out[g];
                  out_next[g] = cfg.out_val[g];
               end
            end
         end else begin : g_gen
            always_comb begin
               oe_next[g]  = (state_next == dagp_pkg::DAGP_ST_ACTIVE) && cfg.dir_out[g];
               out_next[g] = cfg.out_val[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (rst) begin
         oe_reg  <= `DAGP_DIR_RESET;
         out_reg <= `DAGP_OUT_RESET;
      end else begin
         oe_reg  <= oe_next;
         out_reg <= out_next;
      end
   end
   assign pin_oe  = oe_reg;
   assign pin_out = out_reg;

   // ==========================================================
   // Serial chip select interlock and scan format support
   assign spi_select_refused = reset_pin_mode && spi_port_enabled &&
      (spi_port_select == `DAGP_SPI_SEL_SIX || spi_port_select == `DAGP_SPI_SEL_SEVEN);

   // Both wire counts are accepted; only the format code is checked
   assign scan_format_ok = (scan_format <= dagp_pkg::DAGP_OSCAN7) &&
      (scan_two_wire || !scan_two_wire);

   // ==========================================================
   // Assertions
   a_reset_float: assert property (@(posedge clock) rst |=> pin_oe == 3'h0)
      else $error("pins driven after reset");
   a_drive_needs_enable: assert property (@(posedge clock) disable iff (rst)
      (pin_oe[0] | pin_oe[1]) |-> port_active)
      else $error("pin driven while port inactive");
   a_disable_release: assert property (@(posedge clock) disable iff (rst)
      !cfg.port_enable |=> pin_oe[1:0] == 2'h0)
      else $error("pins not released on disable");
   a_conflict_block: assert property (@(posedge clock) disable iff (rst)
      conflict |=> !port_active)
      else $error("port active while scan or serial enabled");
   a_dir_follow: assert property (@(posedge clock) disable iff (rst)
      (cfg.port_enable && !conflict && !port_refused && cfg.dir_out[0]) [*2] |-> pin_oe[0])
      else $error("output pin not driven");
   a_reset_pin_low: assert property (@(posedge clock) disable iff (rst)
      (reset_pin_mode && proc_reset_request) |=> pin_oe[2] && !pin_out[2])
      else $error("processor reset not asserted");
   a_cs_refuse: assert property (@(posedge clock) disable iff (rst)
      (reset_pin_mode && spi_port_enabled && spi_port_select == 3'h7) |-> spi_select_refused)
      else $error("serial port seven not refused");
   a_input_sync: assert property (@(posedge clock) disable iff (rst)
      1'b1 ##3 1'b1 |-> pin_in_value == $past(pin_in, 3))
      else $error("input value not three cycles late");
   a_blocked_float: assert property (@(posedge clock) disable iff (rst)
      port_refused |-> pin_oe[1:0] == 2'h0)
      else $error("pins driven while port refused");
   a_sticky_refusal: assert property (@(posedge clock) disable iff (rst)
      (port_refused && cfg.port_enable) |=> port_refused)
      else $error("refusal dropped while enable held");
   a_enable_grant: assert property (@(posedge clock) disable iff (rst)
      (cfg.port_enable && !conflict && !port_refused) |=> port_active)
      else $error("free port not granted");
   a_idle_float: assert property (@(posedge clock) disable iff (rst)
      !port_active |-> pin_oe[1:0] == 2'h0)
      else $error("general pin driven while port inactive");
   a_pin_two_general: assert property (@(posedge clock) disable iff (rst)
      (!$past(reset_pin_mode) && pin_oe[2]) |-> port_active)
      else $error("pin two driven while port inactive");
   a_reset_pin_release: assert property (@(posedge clock) disable iff (rst)
      (reset_pin_mode && !proc_reset_request) |=> !pin_oe[2])
      else $error("processor reset pin not released");
   a_cs_refuse_six: assert property (@(posedge clock) disable iff (rst)
      (reset_pin_mode && spi_port_enabled && spi_port_select == 3'h6) |-> spi_select_refused)
      else $error("serial port six not refused");
   a_format_accept: assert property (@(posedge clock) disable iff (rst)
      (scan_format <= dagp_pkg::DAGP_OSCAN7) |-> scan_format_ok)
      else $error("supported scan format rejected");
   a_format_reject: assert property (@(posedge clock) disable iff (rst)
      (scan_format > dagp_pkg::DAGP_OSCAN7) |-> !scan_format_ok)
      else $error("unknown scan format accepted");
   a_reset_idle: assert property (@(posedge clock)
      rst |=> !port_active && !port_refused)
      else $error("port state not cleared by reset");
   a_out_follow: assert property (@(posedge clock) disable iff (rst)
      (cfg.port_enable && !conflict && !port_refused && cfg.dir_out[0]) |=> pin_out[0] == $past(cfg.out_val[0]))
      else $error("output value not taken from config");
   a_state_onehot: assert property (@(posedge clock) disable iff (rst)
      $onehot(state_reg))
      else $error("ownership state not one-hot");

endmodule

`default_nettype wire

// file: core/dagp_params.svh
// Constants for the debug adapter general-purpose pin port.
// Assumes inclusion by bare name from the core package and module.
`ifndef DAGP_PARAMS_SVH
`define DAGP_PARAMS_SVH

`define DAGP_PIN_COUNT       3
`define DAGP_RESET_PIN_INDEX 2
`define DAGP_DIR_RESET       3'h0
`define DAGP_OUT_RESET       3'h0
`define DAGP_FORMAT_COUNT    13
`define DAGP_SPI_SEL_SIX     3'h6
`define DAGP_SPI_SEL_SEVEN   3'h7

`endif

// file: core/dagp_pkg.sv
// Types for the debug adapter general-purpose pin port.
// Assumes the params header is on the include path.
`include "dagp_params.svh"
`default_nettype none

package dagp_pkg;

   // Pin group carrier: input, output value, output enable
   typedef struct packed {
      logic [`DAGP_PIN_COUNT-1:0] in_val;
      logic [`DAGP_PIN_COUNT-1:0] out_val;
      logic [`DAGP_PIN_COUNT-1:0] out_en;
   } dagp_pins_type;

   // Host configuration of the port
   typedef struct packed {
      logic                       port_enable;
      logic [`DAGP_PIN_COUNT-1:0] dir_out;
      logic [`DAGP_PIN_COUNT-1:0] out_val;
   } dagp_cfg_type;

   // Scan formats supported by the scan-chain engine
   typedef enum logic [3:0] {
      DAGP_JSCAN0 = 4'h0, DAGP_JSCAN1 = 4'h1, DAGP_JSCAN2 = 4'h2, DAGP_JSCAN3 = 4'h3,
      DAGP_MSCAN  = 4'h4,
      DAGP_OSCAN0 = 4'h5, DAGP_OSCAN1 = 4'h6, DAGP_OSCAN2 = 4'h7, DAGP_OSCAN3 = 4'h8,
      DAGP_OSCAN4 = 4'h9, DAGP_OSCAN5 = 4'hA, DAGP_OSCAN6 = 4'hB, DAGP_OSCAN7 = 4'hC
   } dagp_format_type;

   // Port ownership state
   typedef enum logic [2:0] {
      DAGP_ST_IDLE    = 3'b001,
      DAGP_ST_ACTIVE  = 3'b010,
      DAGP_ST_BLOCKED = 3'b100
   } dagp_state_type;

endpackage

`default_nettype wire

// file: test/dagp_target.sv
// Target-board model facing the general-purpose pins.
// Assumes the port's enables and values arrive as plain vectors.
`default_nettype none
module dagp_target (
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   input  wire logic [2:0] ext_en,
   input  wire logic [2:0] ext_val,
   output logic      [2:0] pin_level,
   output logic            processor_system_reset_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // Port drive wins, else target drive, else weak pull-up
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~(ext_en & ~ext_val));
   // Pin two feeds the processor reset input
   assign processor_system_reset_n = pin_level[2];
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the general-purpose pin port.
// Assumes the design package and the target-board model are compiled first.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [2:0] oe, out, inv;
      logic       act, refd, rstn, sel, fmt;
   } dagp_tb_exp_type;
   logic                      clock = 1'b0, rst = 1'b1, scan_en = 1'b0, spi_en = 1'b0;
   logic                      mode = 1'b0, req = 1'b0, two = 1'b0, m_act, m_ref, m_rstn;
   logic [2:0]                sel = 3'h0, ext_en = 3'h0, ext_val = 3'h0, lvl, h1 = 3'h0;
   logic [2:0]                h2 = 3'h0, p_oe = 3'h0, p_out = 3'h0;
   logic [2:0]                pin_out, pin_oe, pin_in, pin_in_value;
   logic                      port_active, port_refused, spi_select_refused, scan_format_ok;
   dagp_pkg::dagp_cfg_type    cfg = '0;
   dagp_pkg::dagp_format_type fmt = dagp_pkg::DAGP_JSCAN0;
   int                        num_errors = 0, comparisons = 0;
   dagp_tb_exp_type           exp_q[$];
   dagp_port DUT (.clock(clock), .rst(rst), .cfg(cfg), .scan_port_enabled(scan_en),
      .spi_port_enabled(spi_en), .spi_port_select(sel), .reset_pin_mode(mode),
      .proc_reset_request(req), .scan_format(fmt), .scan_two_wire(two), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_in_value(pin_in_value),
      .port_active(port_active), .port_refused(port_refused),
      .spi_select_refused(spi_select_refused), .scan_format_ok(scan_format_ok));
   dagp_target target (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pin_level(pin_in), .processor_system_reset_n(m_rstn));
   initial forever #2.5 clock = ~clock;
   task automatic check(string name, logic [2:0] seen, logic [2:0] want);
      comparisons++;
      if (seen !== want) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, want, seen);
      end
   endtask
   task automatic close_out;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Applies current inputs for one cycle and notes the expected outputs
   task automatic step;
      dagp_tb_exp_type e;
      if (rst || !cfg.port_enable) {m_act, m_ref} = 2'b00;
      else if (scan_en || spi_en || m_ref) {m_act, m_ref} = 2'b01;
      else {m_act, m_ref} = 2'b10;
      e.oe = m_act ? cfg.dir_out : 3'h0;
      e.out = cfg.out_val;
      if (mode && !rst) begin
         e.oe[2] = req;
         e.out[2] = 1'b0;
      end
      // Level sampled at this edge: previous drive with the new target inputs
      lvl = (p_oe & p_out) | (~p_oe & ~(ext_en & ~ext_val));
      e.inv = rst ? 3'h0 : h2;
      h2 = rst ? 3'h0 : h1;
      h1 = rst ? 3'h0 : lvl;
      p_oe = e.oe;
      p_out = e.out;
      lvl = (e.oe & e.out) | (~e.oe & ~(ext_en & ~ext_val));
      e.rstn = lvl[2];
      e.act = m_act;
      e.refd = m_ref;
      e.sel = mode && spi_en && sel >= 3'h6;
      e.fmt = fmt <= 4'hC;
      exp_q.push_back(e);
      @(negedge clock);
   endtask
   always @(posedge clock) begin
      dagp_tb_exp_type e;
      #1;
      if (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check("pin_oe", pin_oe, e.oe);
         check("pin_out", pin_out & pin_oe, e.out & e.oe);
         check("port_active", 3'(port_active), 3'(e.act));
         check("port_refused", 3'(port_refused), 3'(e.refd));
         check("spi_select_refused", 3'(spi_select_refused), 3'(e.sel));
         check("scan_format_ok", 3'(scan_format_ok), 3'(e.fmt));
         check("pin_in_value", pin_in_value, e.inv);
         check("processor_system_reset_n", 3'(m_rstn), 3'(e.rstn));
      end
   end
   initial begin
      #10000;
      num_errors++;
      close_out;
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(77));
      repeat (5) step;
      rst = 1'b0;
      cfg = {1'b1, 3'h5, 3'h3};
      repeat (5) step;
      cfg.port_enable = 1'b0;
      repeat (2) step;
      // Enable, conflicts, sticky refusal
      for (int i = 0; i < 9; i++) begin
         {cfg.port_enable, scan_en, spi_en} = 3'(32'o040450464 >> (3 * i));
         step;
      end
      {mode, spi_en, req} = 3'h7;
      for (int i = 0; i < 8; i++) begin
         sel = 3'(i);
         step;
      end
      {mode, spi_en, req} = 3'h0;
      for (int i = 0; i < 16; i++) begin
         fmt = dagp_pkg::dagp_format_type'(4'(i));
         two = i[0];
         step;
      end
      {ext_en, ext_val} = 6'h3A;
      repeat (4) step;
      for (int i = 0; i < 150; i++) begin
         if (scan_en) begin
            fmt = dagp_pkg::DAGP_JSCAN0;
            step;
         end
         {cfg, sel, mode, req, two, ext_en, ext_val} = 19'($urandom);
         {scan_en, spi_en} = ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
         fmt = dagp_pkg::dagp_format_type'(4'($urandom % 13));
         repeat (1 + $urandom % 5) step;
      end
      {scan_en, spi_en, mode} = 3'h0;
      cfg = {1'b1, 3'h7, 3'h7};
      step;
      rst = 1'b1;
      repeat (2) step;
      rst = 1'b0;
      repeat (2) step;
      repeat (2) @(negedge clock);
      close_out;
   end
endmodule
`default_nettype wire
